// File: pkg/rops_map.vh
// Constants and register map of the remote on/off power sequencer.
// Overview of operation
// [R1] Input high starts, low or floating stops
// [R2] Switch-off request is signalled to the processor
// [R3] Hard-off timeout removes supplies unconditionally
// [R4] Timing selector zero means bypass, no timers
// [R5] Supplies enable after input stable over 2 s
// [R6] Startup hold blocks switch-off routing and power-off
// [R7] Off-debounce 60 s; restored input cancels power-off
// [R8] Hard-off timer follows off-debounce, then supplies off
// [R9] Host must not shut down during off-debounce
// [R10] Power-fail can switch supplies off when enabled
// [R11] Mode 1 remote, mode 2 power-fail, others reserved
// [R12] Power-fail registers only on input driven low
// [R13] Timing settings 5-15 invalid; delays from tick
`ifndef ROPS_MAP_VH
`define ROPS_MAP_VH

// Clock period and tick period in nanoseconds.
`define ROPS_CLK_NS        8
`define ROPS_TICK_NS       1000000
`define ROPS_TICKS_PER_SEC 1000

// Delays in seconds.
`define ROPS_T_DEB_ON_S    2
`define ROPS_T_DEB_OFF_S   60
`define ROPS_T_START1_S    5
`define ROPS_T_START2_S    60
`define ROPS_T_START3_S    1800
`define ROPS_T_START4_S    7200
`define ROPS_T_HARD1_S     60
`define ROPS_T_HARD2_S     300
`define ROPS_T_HARD3_S     7200
`define ROPS_T_HARD4_S     7200

// Selector codes.
`define ROPS_MODE_REMOTE   4'h1
`define ROPS_MODE_PFAIL    4'h2
`define ROPS_TIME_BYPASS   4'h0
`define ROPS_TIME_MAX      4'h4

// Register byte offsets.
`define ROPS_REG_STATUS    12'h000
`define ROPS_REG_MASK      12'h004
`define ROPS_REG_CTRL      12'h008
`define ROPS_REG_STATE     12'h00C

// Status and mask bit positions.
`define ROPS_EV_ON         0
`define ROPS_EV_OFFREQ     1
`define ROPS_EV_CANCEL     2
`define ROPS_EV_HARDOFF    3
`define ROPS_EV_PFAIL      4
`define ROPS_EV_W          5

// Control bit position and reset values.
`define ROPS_CTRL_PFOFF    0
`define ROPS_MASK_RST      5'h00
`define ROPS_CTRL_RST      1'h0

`endif

// File: core/rops_tick.v
// Tick divider producing a one-cycle enable pulse.
`timescale 1ns/1ps
`default_nettype none
module rops_tick #(
  parameter CYCLES = 125000
) (
  input  wire SYS_CLK,
  input  wire RST_N,
  output reg  TICK
);

  reg [31:0] cnt; // Cycles since the last tick.

  // Count up to CYCLES - 1 and pulse TICK once per period of CYCLES cycles.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt  <= 32'h00000000;
      TICK <= 1'b0;
    end else if (cnt >= CYCLES - 1) begin
      cnt  <= 32'h00000000;
      TICK <= 1'b1;
    end else begin
      cnt  <= cnt + 32'h00000001;
      TICK <= 1'b0;
    end
  end

endmodule // rops_tick
`default_nettype wire

// File: core/rops_top.v
// Remote on/off power sequencer with APB registers and interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "rops_map.vh"
module rops_top #(
  parameter TICK_CYCLES   = `ROPS_TICK_NS / `ROPS_CLK_NS,
  parameter TICKS_PER_SEC = `ROPS_TICKS_PER_SEC,
  parameter CNT_W         = 24
) (
  input  wire        SYS_CLK,
  input  wire        RST_N,
  input  wire        ONOFF_PF_IN,
  input  wire [3:0]  MODE_SELECT_SWITCH,
  input  wire [3:0]  TIMING_SELECT_SWITCH,
  output reg         SUPPLY_EN,
  output reg         SHUTDOWN_REQ,
  output wire        IRQ,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output reg         PSLVERR
);

  // One-hot sequencer states.
  localparam [5:0] ST_BYP   = 6'h01; // No timers, supplies on unless held off by power-fail.
  localparam [5:0] ST_OFF   = 6'h02; // Supplies off, on-debounce.
  localparam [5:0] ST_START = 6'h04; // Startup hold.
  localparam [5:0] ST_RUN   = 6'h08; // Normal operation.
  localparam [5:0] ST_DEB   = 6'h10; // Off-debounce window.
  localparam [5:0] ST_HARD  = 6'h20; // Hard-off countdown.

  reg  [1:0]       in_sync;   // Two-stage synchroniser of the pin.
  reg  [3:0]       mode_s1;   // First stage of mode switch.
  reg  [3:0]       mode_s2;   // Synchronised mode switch.
  reg  [3:0]       time_s1;   // First stage of timing switch.
  reg  [3:0]       time_s2;   // Synchronised timing switch.
  reg              in_prev;   // Synchronised level one cycle ago.
  reg  [5:0]       state;     // Sequencer state.
  reg  [5:0]       next_state;
  reg  [CNT_W-1:0] cnt;       // Ticks since state entry.
  reg  [CNT_W-1:0] limit;     // Ticks allowed in the present state.
  reg  [`ROPS_EV_W-1:0] status; // Sticky events.
  reg  [`ROPS_EV_W-1:0] mask;   // Interrupt enables.
  reg  [`ROPS_EV_W-1:0] ev;     // Events of this cycle.
  reg              pf_off_en; // Power-fail shutdown enable.
  reg              pf_off;    // Supplies held off by power-fail.
  reg  [31:0]      next_prdata;
  reg              next_slverr;
  wire             tick;      // One-cycle tick enable.
  wire             in_on;     // Input level, high requests on.
  wire             remote;    // Remote on/off mode selected.
  wire             timed;     // Valid timed setting selected.
  wire             pf_pend;   // Power-fail currently pending.
  wire             expire;    // State time has run out.
  wire             apb_acc;   // APB access phase.
  wire             rd_stat;   // Read of the status register.

  // Slow time base shared by all delays.
  rops_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .TICK    (tick)
  );

  // Seconds to ticks; the product is cut to the counter width.
  function [CNT_W-1:0] secs;
    input [31:0] s;
    reg   [31:0] p;
    begin
      p    = s * TICKS_PER_SEC;
      secs = p[CNT_W-1:0];
    end
  endfunction

  // Pin and switches come from outside, so each passes two flops.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      in_sync <= 2'h0;
      mode_s1 <= 4'h0;
      mode_s2 <= 4'h0;
      time_s1 <= 4'h0;
      time_s2 <= 4'h0;
      in_prev <= 1'b0;
    end else begin
      in_sync <= {in_sync[0], ONOFF_PF_IN};
      mode_s1 <= MODE_SELECT_SWITCH;
      mode_s2 <= mode_s1;
      time_s1 <= TIMING_SELECT_SWITCH;
      time_s2 <= time_s1;
      in_prev <= in_sync[1];
    end
  end

  // [R1] High means on.
  // In remote mode a floating pin is expected to be pulled low outside the block.
  assign in_on  = in_sync[1];
  // [R11] Mode decode.
  // Reserved settings fall back to the power-fail default.
  assign remote = (mode_s2 == `ROPS_MODE_REMOTE);
  // [R4] Bypass at zero.
  // [R13] Invalid settings untimed.
  assign timed  = remote && (time_s2 != `ROPS_TIME_BYPASS) &&
                  (time_s2 <= `ROPS_TIME_MAX);
  // [R12] Low input only.
  // Only a driven-low pin counts, so a high or open pin changes nothing.
  assign pf_pend = !remote && !in_on;
  assign expire  = tick && (cnt == limit);

  // Per-state time limit; startup hold and hard-off limits come from the timing switch.
  always @* begin
    limit = {CNT_W{1'b1}};
    case (state)
      // [R5] On-debounce limit.
      ST_OFF:   limit = secs(`ROPS_T_DEB_ON_S);
      // [R6] Startup hold limit.
      ST_START: begin
        case (time_s2)
          4'h1:    limit = secs(`ROPS_T_START1_S);
          4'h2:    limit = secs(`ROPS_T_START2_S);
          4'h3:    limit = secs(`ROPS_T_START3_S);
          default: limit = secs(`ROPS_T_START4_S);
        endcase
      end
      // [R7] Off-debounce limit.
      ST_DEB:   limit = secs(`ROPS_T_DEB_OFF_S);
      // [R8] Hard-off limit.
      ST_HARD:  begin
        case (time_s2)
          4'h1:    limit = secs(`ROPS_T_HARD1_S);
          4'h2:    limit = secs(`ROPS_T_HARD2_S);
          4'h3:    limit = secs(`ROPS_T_HARD3_S);
          default: limit = secs(`ROPS_T_HARD4_S);
        endcase
      end
      default:  limit = {CNT_W{1'b1}};
    endcase
  end

  // Next state; leaving a timed setting drops straight to bypass.
  always @* begin
    next_state = state;
    case (state)
      ST_BYP: begin
        // Entering timed mode keeps a running system up.
        if (timed) begin
          next_state = ST_RUN;
        end
      end
      ST_OFF: begin
        // [R5] Debounce before power.
        if (expire && in_on) begin
          next_state = ST_START;
        end
      end
      ST_START: begin
        // [R6] Hold ignores the input.
        if (expire) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!in_on) begin
          next_state = ST_DEB;
        end
      end
      ST_DEB: begin
        // [R7] Restore cancels shutdown.
        if (in_on) begin
          next_state = ST_RUN;
        end else if (expire) begin
          next_state = ST_HARD;
        end
      end
      ST_HARD: begin
        // [R3] Unconditional hard off.
        // [R8] Input return is ignored.
        if (expire) begin
          next_state = ST_OFF;
        end
      end
      default: next_state = ST_BYP;
    endcase
    if (!timed) begin
      next_state = ST_BYP;
    end
  end

  // State register and tick counter, cleared on every state change.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_BYP;
      cnt   <= {CNT_W{1'b0}};
    end else begin
      state <= next_state;
      if (next_state != state) begin
        cnt <= {CNT_W{1'b0}};
      end else if (state == ST_OFF && !in_on) begin
        // [R5] Continuous input needed.
        cnt <= {CNT_W{1'b0}};
      end else if (tick && cnt != limit) begin
        cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Power-fail latch; released once the pin returns high.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pf_off <= 1'b0;
    end else if (remote || in_on) begin
      pf_off <= 1'b0;
    end else if (pf_pend && pf_off_en) begin
      // [R10] Power-fail switch-off.
      pf_off <= 1'b1;
    end
  end

  // Supply enable and processor notification, both registered.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SUPPLY_EN    <= 1'b0;
      SHUTDOWN_REQ <= 1'b0;
    end else begin
      case (next_state)
        ST_BYP: begin
          // [R4] Untimed supplies.
          // Remote mode never waits for the power-fail latch to drop, so a
          // switch from power-fail to remote cannot raise a request unpowered.
          SUPPLY_EN    <= remote || !pf_off;
          SHUTDOWN_REQ <= remote && !in_on;
        end
        ST_OFF: begin
          SUPPLY_EN    <= 1'b0;
          SHUTDOWN_REQ <= 1'b0;
        end
        ST_START, ST_RUN: begin
          // [R6] No request during hold.
          SUPPLY_EN    <= 1'b1;
          SHUTDOWN_REQ <= 1'b0;
        end
        default: begin
          // [R2] Notify the processor.
          // [R9] Host waits for hard-off.
          SUPPLY_EN    <= 1'b1;
          SHUTDOWN_REQ <= 1'b1;
        end
      endcase
    end
  end

  // Events of this cycle feeding the sticky status bits.
  always @* begin
    ev = {`ROPS_EV_W{1'b0}};
    ev[`ROPS_EV_ON]      = (state == ST_OFF) && (next_state == ST_START);
    ev[`ROPS_EV_OFFREQ]  = (state == ST_RUN) && (next_state == ST_DEB);
    ev[`ROPS_EV_CANCEL]  = (state == ST_DEB) && (next_state == ST_RUN);
    ev[`ROPS_EV_HARDOFF] = (state == ST_HARD) && (next_state == ST_OFF);
    ev[`ROPS_EV_PFAIL]   = !remote && in_prev && !in_on;
  end

  // APB slave: zero wait states, error on unmapped offsets.
  assign PREADY  = 1'b1;
  assign apb_acc = PSEL && PENABLE;
  assign rd_stat = apb_acc && !PWRITE && (PADDR == `ROPS_REG_STATUS);
  // A level interrupt while any unmasked status bit is set.
  assign IRQ     = |(status & mask);

  // Read data and error answer of the current access.
  always @* begin
    next_prdata = 32'h00000000;
    next_slverr = 1'b0;
    case (PADDR)
      `ROPS_REG_STATUS: next_prdata[`ROPS_EV_W-1:0] = status;
      `ROPS_REG_MASK:   next_prdata[`ROPS_EV_W-1:0] = mask;
      `ROPS_REG_CTRL:   next_prdata[`ROPS_CTRL_PFOFF] = pf_off_en;
      `ROPS_REG_STATE: begin
        next_prdata[5:0]   = state;
        next_prdata[11:8]  = mode_s2;
        next_prdata[15:12] = time_s2;
        next_prdata[16]    = in_on;
        next_prdata[17]    = pf_pend;
        next_prdata[18]    = SUPPLY_EN;
        next_prdata[19]    = SHUTDOWN_REQ;
      end
      default: next_slverr = 1'b1;
    endcase
  end

  // Registered answer: PRDATA holds the word read in the last setup.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PRDATA  <= PWRITE ? 32'h00000000 : next_prdata;
      PSLVERR <= next_slverr;
    end
  end

  // Control registers written in the access phase.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask      <= `ROPS_MASK_RST;
      pf_off_en <= `ROPS_CTRL_RST;
    end else if (apb_acc && PWRITE) begin
      if (PADDR == `ROPS_REG_MASK) begin
        mask <= PWDATA[`ROPS_EV_W-1:0];
      end
      if (PADDR == `ROPS_REG_CTRL) begin
        pf_off_en <= PWDATA[`ROPS_CTRL_PFOFF];
      end
    end
  end

  // Sticky status, cleared by its read; a new event wins the clear.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      status <= {`ROPS_EV_W{1'b0}};
    end else if (rd_stat) begin
      status <= ev;
    end else begin
      status <= status | ev;
    end
  end

endmodule // rops_top
`default_nettype wire

// File: tb/rops_ignition.sv
// Model of the external on/off control line for the sequencer bench.
`timescale 1ns/1ps
`default_nettype none
module rops_ignition (
  input  wire logic [1:0] drive,
  input  wire logic       pf_mode,
  output logic            pin
);
  // supply level starts
  // Code 1 pulls to supply, 0 grounds it, 2 floats.
  // An open line reads low in remote mode, so it means off.
  // In power-fail mode the board pulls it high, so open raises no failure.
  assign pin = (drive == 2'h1) || (pf_mode && drive == 2'h2);
endmodule // rops_ignition
`default_nettype wire

// File: tb/rops_checker.sv
// Port-level assertions for the remote on/off power sequencer.
`timescale 1ns/1ps
`default_nettype none
module rops_checker #(
  parameter TICK_CYCLES   = 4,
  parameter TICKS_PER_SEC = 2,
  parameter CNT_W         = 24
) (
  input wire       SYS_CLK,
  input wire       RST_N,
  input wire       ONOFF_PF_IN,
  input wire [3:0] MODE_SELECT_SWITCH,
  input wire [3:0] TIMING_SELECT_SWITCH,
  input wire       SUPPLY_EN,
  input wire       SHUTDOWN_REQ
);
  // Clock cycles in one second of the slow time base.
  localparam int SEC  = TICKS_PER_SEC * TICK_CYCLES;
  localparam int HOLD = 5 * SEC - TICK_CYCLES;
  // Worst-case low time from startup hold to hard-off, tick slack added.
  localparam int LIM  = 125 * SEC + 5 * TICK_CYCLES + 4;
  logic [15:0] hi_cnt;   // Cycles the line has been high.
  logic [15:0] lo_cnt;   // Cycles the line has been low.
  logic [15:0] cfg_cnt;  // Cycles in remote mode with timing one.
  wire         cfg1 = (MODE_SELECT_SWITCH == 4'h1) &&
                      (TIMING_SELECT_SWITCH == 4'h1);
  // Run lengths; they wrap after 65535, far beyond any bench run.
  always @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hi_cnt <= 16'h0000;
      lo_cnt <= 16'h0000;
      cfg_cnt <= 16'h0000;
    end else begin
      hi_cnt <= ONOFF_PF_IN ? hi_cnt + 16'h0001 : 16'h0000;
      lo_cnt <= ONOFF_PF_IN ? 16'h0000 : lo_cnt + 16'h0001;
      cfg_cnt <= cfg1 ? cfg_cnt + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  AST_REQ_SUPPLY: assert property (SHUTDOWN_REQ |-> SUPPLY_EN)
    else $error("request raised with supplies off");
  AST_PF_QUIET: assert property (
    (MODE_SELECT_SWITCH == 4'h2) [*4] |-> !SHUTDOWN_REQ)
    else $error("request raised in power-fail mode");
  AST_BYPASS: assert property (
    (MODE_SELECT_SWITCH == 4'h1 && TIMING_SELECT_SWITCH == 4'h0 &&
     $stable(ONOFF_PF_IN)) [*6] |-> SUPPLY_EN && SHUTDOWN_REQ == !ONOFF_PF_IN)
    else $error("bypass outputs wrong");
  AST_INVALID: assert property (
    (MODE_SELECT_SWITCH == 4'h1 && TIMING_SELECT_SWITCH == 4'hF) [*6]
    |-> SUPPLY_EN)
    else $error("invalid timing not untimed");
  AST_ON_DEB: assert property (
    $rose(SUPPLY_EN) && cfg_cnt > 16'h0008 |-> hi_cnt >= 2 * SEC)
    else $error("supplies on before debounce");
  AST_START_HOLD: assert property (
    $rose(SUPPLY_EN) && cfg_cnt > 16'h0008
    |=> (SUPPLY_EN && !SHUTDOWN_REQ) throughout (##HOLD 1'b1))
    else $error("request during startup hold");
  AST_CANCEL: assert property (
    $rose(ONOFF_PF_IN) && SHUTDOWN_REQ && cfg_cnt > lo_cnt &&
    lo_cnt < 60 * SEC |-> ##[1:6] !SHUTDOWN_REQ)
    else $error("restored input did not cancel");
  AST_HARD_OFF: assert property (
    lo_cnt == LIM && cfg_cnt >= LIM |-> !SUPPLY_EN)
    else $error("supplies still on after timeout");
endmodule // rops_checker
bind rops_top rops_checker #(
  .TICK_CYCLES(TICK_CYCLES), .TICKS_PER_SEC(TICKS_PER_SEC), .CNT_W(CNT_W)
) i_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .ONOFF_PF_IN(ONOFF_PF_IN),
  .MODE_SELECT_SWITCH(MODE_SELECT_SWITCH),
  .TIMING_SELECT_SWITCH(TIMING_SELECT_SWITCH),
  .SUPPLY_EN(SUPPLY_EN), .SHUTDOWN_REQ(SHUTDOWN_REQ)
);
`default_nettype wire

// File: tb/rops_tb_top.sv
// Self-checking bench for the remote on/off power sequencer.
`timescale 1ns/1ps
`default_nettype none
module rops_tb_top;
  logic        clk, rst_n, pin, supply, req, irq;
  logic        psel, penable, pwrite, pready, pslverr, err;
  logic [1:0]  drive;    // Line code: 0 ground, 1 supply, 2 float.
  logic [3:0]  mode, timing;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_mismatch, n_compared;
  rops_ignition i_ign (.drive(drive), .pf_mode(mode != 4'h1), .pin(pin));
  // Short tick so one second is eight clocks.
  rops_top #(.TICK_CYCLES(4), .TICKS_PER_SEC(2), .CNT_W(24)) i_dut (
    .SYS_CLK(clk), .RST_N(rst_n), .ONOFF_PF_IN(pin),
    .MODE_SELECT_SWITCH(mode), .TIMING_SELECT_SWITCH(timing),
    .SUPPLY_EN(supply), .SHUTDOWN_REQ(req), .IRQ(irq), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  // Prints the counts and the verdict, then ends the run.
  task summarize;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      $display("[FAIL] %0t bus answer never came", $time);
      n_mismatch++;
      summarize;
    end
  endtask
  // Waits up to hi cycles for an output level; it must not come before lo.
  task expect_in(input logic which, input logic v, input int lo, input int hi);
    int n;
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      s = which ? req : supply;
    end while (s !== v && n < hi);
    if (s !== v) begin
      $display("[FAIL] %0t output level never came", $time);
      n_mismatch++;
      summarize;
    end
    chk({31'h0, n >= lo}, 32'h1);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    drive = 2'h1;
    mode = 4'h1;
    timing = 4'h0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    n_mismatch = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    chk({30'h0, supply, req}, 32'h2);
    timing <= 4'hF;
    repeat (10) @(posedge clk);
    chk({30'h0, supply, req}, 32'h2);
    // An open line in remote mode asks for switch-off.
    drive <= 2'h2;
    expect_in(1'b1, 1'b1, 1, 8);
    drive <= 2'h1;
    timing <= 4'h1;
    repeat (8) @(posedge clk);
    // Line held low right through the hard-off.
    drive <= 2'h0;
    expect_in(1'b1, 1'b1, 1, 8);
    expect_in(1'b0, 1'b0, 955, 1000);
    repeat (60) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd & 32'hA, 32'hA);
    chk({31'h0, irq}, 32'h0);
    drive <= 2'h1;
    expect_in(1'b0, 1'b1, 18, 28);
    // Release during the startup hold is not passed on until it ends.
    drive <= 2'h0;
    expect_in(1'b1, 1'b1, 36, 60);
    repeat (100) @(posedge clk);
    // host keeps running
    // The host only waits here, so restoring the line keeps it alive.
    drive <= 2'h1;
    expect_in(1'b1, 1'b0, 1, 8);
    chk({31'h0, supply}, 32'h1);
    drive <= 2'h0;
    expect_in(1'b1, 1'b1, 1, 8);
    repeat (600) @(posedge clk);
    chk({31'h0, supply}, 32'h1);
    // Restoring the line in the hard-off phase changes nothing.
    drive <= 2'h1;
    expect_in(1'b0, 1'b0, 355, 400);
    expect_in(1'b0, 1'b1, 16, 28);
    repeat (50) @(posedge clk);
    apb(1'b1, 12'h004, 32'h10);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h10);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    timing <= 4'h0;
    mode <= 4'h2;
    repeat (8) @(posedge clk);
    // An open line reads high in power-fail mode and changes nothing.
    drive <= 2'h2;
    repeat (8) @(posedge clk);
    chk({30'h0, supply, irq}, 32'h2);
    drive <= 2'h0;
    expect_in(1'b0, 1'b0, 1, 8);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd & 32'h10, 32'h10);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    drive <= 2'h1;
    expect_in(1'b0, 1'b1, 1, 8);
    repeat (8) @(posedge clk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd & 32'h10, 32'h0);
    summarize;
  end
endmodule // rops_tb_top
`default_nettype wire
